// ===== include/psr_pkg.sv
// Constants and encodings for the power-state and reset-default block.
//
// Contract
// - Regulator enable output is high at startup and after any Backup wake-up.
// - Regulator enable output is low while the device sits in Backup mode.
// - I/O supply monitor wakes from Backup only on a falling supply.
// - Backup exits on timer, RTC, supply monitor, wake pins, tamper or force-wake.
// - GPIO direction, level and pull freeze on entry to Backup or Wait.
// - First power-up executes from boot ROM until boot program finishes setup.
// - After power cycle slow clock is internal RC, slow crystal disabled.
// - Power cycle, reset or wake sets main clock to fast RC at lowest step.
// - Power cycle, reset or wake disables fast crystal and both PLLs.
// - Power cycle enables core brownout, its core reset and backup POR.
// - Power cycle leaves the I/O supply monitor disabled until software enables it.
// - Power cycle, reset or wake clears flash wait states to zero.
// - Any reset enables core 0 cache; effective only at the cached flash alias.
// - Any reset holds the second subsystem in reset with clocks stopped.
// - Reset or Backup wake reapplies clock, oscillator, flash, cache, subsystem defaults.
// - Slow clock select, brownout, backup POR, monitor mode survive core reset.
// - Slow crystal may be chosen as reference of the low-frequency PLL.
// - High-frequency PLL output may be selected as the main clock.
// - Active mode selects fast RC, crystal or PLLs; unused peripheral clocks gate off.
package psr_pkg;

    // ****************************************
    // Encodings
    // ****************************************
    typedef enum logic [1:0] {
        PSR_ST_ACTIVE = 2'b00,
        PSR_ST_WAIT = 2'b01,
        PSR_ST_BACKUP = 2'b10,
        PSR_ST_WAKE = 2'b11
    } psr_state_t;

    localparam logic [1:0] MAIN_SRC_FAST_RC = 2'h0;
    localparam logic [1:0] MAIN_SRC_XTAL = 2'h1;
    localparam logic [1:0] MAIN_SRC_LF_PLL = 2'h2;
    localparam logic [1:0] MAIN_SRC_HF_PLL = 2'h3;

    // Fast RC steps: 0 is the lowest (4 MHz).
    localparam logic [1:0] FAST_RC_LOWEST = 2'h0;

    // ****************************************
    // Widths
    // ****************************************
    localparam int WAKE_PIN_W = 14;
    localparam int TAMPER_W = 2;
    localparam int GPIO_W = 32;
    localparam int PCLK_W = 32;
    localparam int FWS_W = 4;
    localparam int SM_MODE_W = 4;
    localparam int CAUSE_W = 6;

    // Wake cause bit positions.
    localparam int CAUSE_TIMER = 0;
    localparam int CAUSE_RTC = 1;
    localparam int CAUSE_SUPPLY = 2;
    localparam int CAUSE_PIN = 3;
    localparam int CAUSE_TAMPER = 4;
    localparam int CAUSE_FORCE = 5;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic RST_REGULATOR_ON = 1'b1;
    localparam logic RST_SLOW_XTAL = 1'b0;
    localparam logic RST_BOD_DISABLE = 1'b0;
    localparam logic RST_BUPOR_EN = 1'b1;
    localparam logic [SM_MODE_W-1:0] RST_SM_MODE = 4'h0;
    localparam logic [FWS_W-1:0] RST_FWS = 4'h0;
    localparam logic RST_CACHE_EN = 1'b1;
    localparam logic RST_SUB1_RESET = 1'b1;
    localparam logic [PCLK_W-1:0] RST_PCLK = 32'h0000_0000;
    localparam logic RST_BOOT_ROM = 1'b1;

endpackage : psr_pkg

// ===== src/psr_wake_collect.sv
// Backup-mode wake-up source collector.
`timescale 1ns/100ps
`default_nettype none
module psr_wake_collect (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Arming
    input wire logic i_armed,
    input wire logic i_monitor_en,
    // Sources
    input wire logic i_timer_alarm,
    input wire logic i_rtc_alarm,
    input wire logic i_io_supply_ok,
    input wire logic [psr_pkg::WAKE_PIN_W-1:0] i_wake_pins,
    input wire logic [psr_pkg::WAKE_PIN_W-1:0] i_wake_pin_en,
    input wire logic [psr_pkg::TAMPER_W-1:0] i_tamper_inputs,
    input wire logic i_force_wake_pin,
    input wire logic i_power_switch_state,
    // Result
    output logic o_wake,
    output logic [psr_pkg::CAUSE_W-1:0] o_cause
);

    logic supply_prev_reg;
    logic [psr_pkg::CAUSE_W-1:0] cause_next;

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            supply_prev_reg <= 1'b0;
        else
            supply_prev_reg <= i_io_supply_ok;
    end

    always_comb
    begin
        cause_next = '0;
        cause_next[psr_pkg::CAUSE_TIMER] = i_timer_alarm;
        cause_next[psr_pkg::CAUSE_RTC] = i_rtc_alarm;
        // A rising supply never counts; only a drop is a system alert.
        cause_next[psr_pkg::CAUSE_SUPPLY] = i_monitor_en & supply_prev_reg & ~i_io_supply_ok;
        cause_next[psr_pkg::CAUSE_PIN] = |(i_wake_pins & i_wake_pin_en);
        cause_next[psr_pkg::CAUSE_TAMPER] = |i_tamper_inputs;
        cause_next[psr_pkg::CAUSE_FORCE] = i_force_wake_pin | i_power_switch_state;
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_wake <= 1'b0;
            o_cause <= '0;
        end
        else
        begin
            o_wake <= i_armed & (|cause_next);
            if (i_armed && (|cause_next))
                o_cause <= cause_next;
        end
    end

endmodule : psr_wake_collect
`default_nettype wire

// ===== src/psr_gpio_hold.sv
// GPIO configuration keeper across low-power modes.
`timescale 1ns/100ps
`default_nettype none
module psr_gpio_hold (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Control
    input wire logic i_hold,
    // Live configuration
    input wire logic [psr_pkg::GPIO_W-1:0] i_dir,
    input wire logic [psr_pkg::GPIO_W-1:0] i_level,
    input wire logic [psr_pkg::GPIO_W-1:0] i_pull_up,
    input wire logic [psr_pkg::GPIO_W-1:0] i_pull_down,
    // Applied configuration
    output logic [psr_pkg::GPIO_W-1:0] o_dir,
    output logic [psr_pkg::GPIO_W-1:0] o_level,
    output logic [psr_pkg::GPIO_W-1:0] o_pull_up,
    output logic [psr_pkg::GPIO_W-1:0] o_pull_down
);

    // The pads follow the live settings only outside low-power modes.
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_dir <= '0;
            o_level <= '0;
            o_pull_up <= '0;
            o_pull_down <= '0;
        end
        else if (!i_hold)
        begin
            o_dir <= i_dir;
            o_level <= i_level;
            o_pull_up <= i_pull_up;
            o_pull_down <= i_pull_down;
        end
    end

endmodule : psr_gpio_hold
`default_nettype wire

// ===== src/psr_top.sv
// Power-state sequencer with reset defaults and battery-backed settings.
`timescale 1ns/100ps
`default_nettype none
module psr_top (
    // Clock and resets
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_backup_por,
    // Mode requests
    input wire logic i_backup_enter,
    input wire logic i_wait_enter,
    input wire logic i_wait_wake,
    input wire logic i_boot_done,
    // Wake sources
    input wire logic i_periodic_timer,
    input wire logic i_rtc_alarm,
    input wire logic i_io_supply_ok,
    input wire logic [psr_pkg::WAKE_PIN_W-1:0] i_wake_pins,
    input wire logic [psr_pkg::WAKE_PIN_W-1:0] i_wake_pin_en,
    input wire logic [psr_pkg::TAMPER_W-1:0] i_tamper_inputs,
    input wire logic i_force_wake_pin,
    input wire logic i_power_switch_state,
    // Retained settings write
    input wire logic i_backup_cfg_wr,
    input wire logic i_slow_xtal_select,
    input wire logic i_core_brownout_disable,
    input wire logic i_backup_por_enable,
    input wire logic [psr_pkg::SM_MODE_W-1:0] i_supply_monitor_mode,
    // Clock configuration write
    input wire logic i_clk_cfg_wr,
    input wire logic [1:0] i_main_clk_src,
    input wire logic [1:0] i_fast_rc_step,
    input wire logic i_xtal_en,
    input wire logic i_low_freq_pll_en,
    input wire logic i_high_freq_pll_en,
    input wire logic i_lf_pll_ref_xtal,
    input wire logic i_hf_pll_from_lf,
    // Other configuration writes
    input wire logic i_fws_wr,
    input wire logic [psr_pkg::FWS_W-1:0] i_flash_wait_states,
    input wire logic i_cache_wr,
    input wire logic i_cache_en,
    input wire logic i_sub1_release,
    input wire logic i_sub1_stop,
    input wire logic i_pclk_wr,
    input wire logic [psr_pkg::PCLK_W-1:0] i_pclk_en,
    // Live GPIO configuration
    input wire logic [psr_pkg::GPIO_W-1:0] i_gpio_dir,
    input wire logic [psr_pkg::GPIO_W-1:0] i_gpio_level,
    input wire logic [psr_pkg::GPIO_W-1:0] i_gpio_pull_up,
    input wire logic [psr_pkg::GPIO_W-1:0] i_gpio_pull_down,
    // Power and mode status
    output logic o_regulator_off_out,
    output logic [1:0] o_power_mode,
    output logic o_boot_from_rom,
    output logic [psr_pkg::CAUSE_W-1:0] o_wake_cause,
    // Retained settings
    output logic o_slow_xtal_select,
    output logic o_core_brownout_disable,
    output logic o_backup_por_enable,
    output logic [psr_pkg::SM_MODE_W-1:0] o_supply_monitor_mode,
    // Clock generator controls
    output logic [1:0] o_main_clk_src,
    output logic [1:0] o_fast_rc_step,
    output logic o_xtal_en,
    output logic o_low_freq_pll_en,
    output logic o_high_freq_pll_en,
    output logic o_lf_pll_ref_xtal,
    output logic o_hf_pll_from_lf,
    output logic o_core_clk_en,
    output logic [psr_pkg::PCLK_W-1:0] o_periph_clk_en,
    // Memory and subsystem controls
    output logic [psr_pkg::FWS_W-1:0] o_flash_wait_states,
    output logic o_core0_cache_ctrl,
    output logic o_sub1_reset,
    output logic o_sub1_clk_en,
    // Held GPIO configuration
    output logic [psr_pkg::GPIO_W-1:0] o_gpio_dir,
    output logic [psr_pkg::GPIO_W-1:0] o_gpio_level,
    output logic [psr_pkg::GPIO_W-1:0] o_gpio_pull_up,
    output logic [psr_pkg::GPIO_W-1:0] o_gpio_pull_down
);

    // ****************************************
    // Declarations
    // ****************************************
    psr_pkg::psr_state_t state_reg;
    psr_pkg::psr_state_t state_next;
    logic wake;
    logic [psr_pkg::CAUSE_W-1:0] wake_cause;
    logic defaults_apply;
    logic active;
    logic gpio_hold;

    assign defaults_apply = (state_reg == psr_pkg::PSR_ST_WAKE);
    assign active = (state_reg == psr_pkg::PSR_ST_ACTIVE);

    // ****************************************
    // Power-state sequencer
    // ****************************************
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            psr_pkg::PSR_ST_ACTIVE:
            begin
                if (i_backup_enter)
                    state_next = psr_pkg::PSR_ST_BACKUP;
                else if (i_wait_enter)
                    state_next = psr_pkg::PSR_ST_WAIT;
            end
            psr_pkg::PSR_ST_WAIT:
            begin
                if (i_wait_wake)
                    state_next = psr_pkg::PSR_ST_ACTIVE;
            end
            psr_pkg::PSR_ST_BACKUP:
            begin
                if (wake)
                    state_next = psr_pkg::PSR_ST_WAKE;
            end
            psr_pkg::PSR_ST_WAKE:
                state_next = psr_pkg::PSR_ST_ACTIVE;
        endcase
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            state_reg <= psr_pkg::PSR_ST_ACTIVE;
        else
            state_reg <= state_next;
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            o_power_mode <= psr_pkg::PSR_ST_ACTIVE;
        else
            o_power_mode <= state_next;
    end

    // Low while in Backup so the board can switch the main regulator off.
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            o_regulator_off_out <= psr_pkg::RST_REGULATOR_ON;
        else
            o_regulator_off_out <= (state_next != psr_pkg::PSR_ST_BACKUP);
    end

    // The hold is taken one cycle before the mode flag, so the pads
    // freeze with the settings seen just before entry.
    assign gpio_hold = (state_reg == psr_pkg::PSR_ST_WAIT) || (state_reg == psr_pkg::PSR_ST_BACKUP);

    // ****************************************
    // Wake-up sources
    // ****************************************
    psr_wake_collect u_wake (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_armed(state_reg == psr_pkg::PSR_ST_BACKUP),
        .i_monitor_en(|o_supply_monitor_mode),
        .i_timer_alarm(i_periodic_timer),
        .i_rtc_alarm(i_rtc_alarm),
        .i_io_supply_ok(i_io_supply_ok),
        .i_wake_pins(i_wake_pins),
        .i_wake_pin_en(i_wake_pin_en),
        .i_tamper_inputs(i_tamper_inputs),
        .i_force_wake_pin(i_force_wake_pin),
        .i_power_switch_state(i_power_switch_state),
        .o_wake(wake),
        .o_cause(wake_cause)
    );

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            o_wake_cause <= '0;
        else if (wake)
            o_wake_cause <= wake_cause;
    end

    // ****************************************
    // Battery-backed settings
    // ****************************************
    // Only the backup POR clears these; a core reset or wake leaves them.
    always_ff @(posedge i_clock or posedge i_backup_por)
    begin
        if (i_backup_por)
        begin
            o_slow_xtal_select <= psr_pkg::RST_SLOW_XTAL;
            o_core_brownout_disable <= psr_pkg::RST_BOD_DISABLE;
            o_backup_por_enable <= psr_pkg::RST_BUPOR_EN;
            o_supply_monitor_mode <= psr_pkg::RST_SM_MODE;
        end
        else if (i_backup_cfg_wr && active)
        begin
            o_slow_xtal_select <= i_slow_xtal_select;
            o_core_brownout_disable <= i_core_brownout_disable;
            o_backup_por_enable <= i_backup_por_enable;
            o_supply_monitor_mode <= i_supply_monitor_mode;
        end
    end

    // The boot-ROM flag lives in the backup area, so only a full power
    // cycle sends execution back to the ROM.
    always_ff @(posedge i_clock or posedge i_backup_por)
    begin
        if (i_backup_por)
            o_boot_from_rom <= psr_pkg::RST_BOOT_ROM;
        else if (i_boot_done)
            o_boot_from_rom <= 1'b0;
    end

    // ****************************************
    // Clock generator controls
    // ****************************************
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_main_clk_src <= psr_pkg::MAIN_SRC_FAST_RC;
            o_fast_rc_step <= psr_pkg::FAST_RC_LOWEST;
            o_xtal_en <= 1'b0;
            o_low_freq_pll_en <= 1'b0;
            o_high_freq_pll_en <= 1'b0;
            o_lf_pll_ref_xtal <= 1'b0;
            o_hf_pll_from_lf <= 1'b0;
        end
        else if (defaults_apply)
        begin
            o_main_clk_src <= psr_pkg::MAIN_SRC_FAST_RC;
            o_fast_rc_step <= psr_pkg::FAST_RC_LOWEST;
            o_xtal_en <= 1'b0;
            o_low_freq_pll_en <= 1'b0;
            o_high_freq_pll_en <= 1'b0;
            o_lf_pll_ref_xtal <= 1'b0;
            o_hf_pll_from_lf <= 1'b0;
        end
        else if (i_clk_cfg_wr && active)
        begin
            o_main_clk_src <= i_main_clk_src;
            o_fast_rc_step <= i_fast_rc_step;
            o_xtal_en <= i_xtal_en;
            o_low_freq_pll_en <= i_low_freq_pll_en;
            o_high_freq_pll_en <= i_high_freq_pll_en;
            // The slow crystal can only be the reference once it runs.
            o_lf_pll_ref_xtal <= i_lf_pll_ref_xtal & o_slow_xtal_select;
            o_hf_pll_from_lf <= i_hf_pll_from_lf;
        end
    end

    // Core and bus clocks stop outside Active mode.
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            o_core_clk_en <= 1'b1;
        else
            o_core_clk_en <= (state_next == psr_pkg::PSR_ST_ACTIVE);
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            o_periph_clk_en <= psr_pkg::RST_PCLK;
        else if (defaults_apply)
            o_periph_clk_en <= psr_pkg::RST_PCLK;
        else if (i_pclk_wr && active)
            o_periph_clk_en <= i_pclk_en;
    end

    // ****************************************
    // Flash, cache and second subsystem
    // ****************************************
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            o_flash_wait_states <= psr_pkg::RST_FWS;
        else if (defaults_apply)
            o_flash_wait_states <= psr_pkg::RST_FWS;
        else if (i_fws_wr && active)
            o_flash_wait_states <= i_flash_wait_states;
    end

    // Caching only helps code linked at the cached flash alias.
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            o_core0_cache_ctrl <= psr_pkg::RST_CACHE_EN;
        else if (defaults_apply)
            o_core0_cache_ctrl <= psr_pkg::RST_CACHE_EN;
        else if (i_cache_wr && active)
            o_core0_cache_ctrl <= i_cache_en;
    end

    // Stop wins over release when both arrive together.
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            o_sub1_reset <= psr_pkg::RST_SUB1_RESET;
        else if (defaults_apply || i_sub1_stop)
            o_sub1_reset <= psr_pkg::RST_SUB1_RESET;
        else if (i_sub1_release && active)
            o_sub1_reset <= 1'b0;
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            o_sub1_clk_en <= 1'b0;
        else if (defaults_apply || i_sub1_stop)
            o_sub1_clk_en <= 1'b0;
        else if (i_sub1_release && active)
            o_sub1_clk_en <= 1'b1;
        else if (state_next != psr_pkg::PSR_ST_ACTIVE)
            o_sub1_clk_en <= 1'b0;
        else
            o_sub1_clk_en <= ~o_sub1_reset;
    end

    // ****************************************
    // GPIO hold
    // ****************************************
    psr_gpio_hold u_gpio (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_hold(gpio_hold || (state_next != psr_pkg::PSR_ST_ACTIVE)),
        .i_dir(i_gpio_dir),
        .i_level(i_gpio_level),
        .i_pull_up(i_gpio_pull_up),
        .i_pull_down(i_gpio_pull_down),
        .o_dir(o_gpio_dir),
        .o_level(o_gpio_level),
        .o_pull_up(o_gpio_pull_up),
        .o_pull_down(o_gpio_pull_down)
    );

endmodule : psr_top
`default_nettype wire

// ===== bench/psr_top_props.sv
// Port-level assertions for the power-state sequencer.
`timescale 1ns/100ps
`default_nettype none
module psr_top_props (
    // Clock and resets
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_backup_por,
    // Inputs watched
    input wire logic i_backup_enter,
    input wire logic i_rtc_alarm,
    input wire logic i_power_switch_state,
    input wire logic i_io_supply_ok,
    input wire logic i_backup_cfg_wr,
    // Outputs watched
    input wire logic o_regulator_off_out,
    input wire logic [1:0] o_power_mode,
    input wire logic [psr_pkg::CAUSE_W-1:0] o_wake_cause,
    input wire logic [psr_pkg::SM_MODE_W-1:0] o_supply_monitor_mode,
    input wire logic [1:0] o_main_clk_src,
    input wire logic o_xtal_en,
    input wire logic o_high_freq_pll_en,
    input wire logic [psr_pkg::FWS_W-1:0] o_flash_wait_states,
    input wire logic o_core0_cache_ctrl,
    input wire logic o_sub1_reset,
    input wire logic [psr_pkg::GPIO_W-1:0] o_gpio_dir
);
    default clocking @(posedge i_clock);
    endclocking
    default disable iff (i_rst || i_backup_por);
    // The wake state lasts one cycle, so a stuck sequencer shows up at once.
    sequence s_wake_exit;
        o_power_mode == 2'h3 ##1 o_power_mode == 2'h0;
    endsequence
    AST_REG_OFF: assert property (o_power_mode == 2'h2 |-> !o_regulator_off_out)
        else $error("regulator enabled in backup");
    AST_REG_ON: assert property (o_power_mode != 2'h2 |-> o_regulator_off_out)
        else $error("regulator off outside backup");
    AST_ENTER: assert property (o_power_mode == 2'h0 && i_backup_enter |=> o_power_mode == 2'h2)
        else $error("backup request lost");
    AST_WAKE: assert property (
        o_power_mode == 2'h2 && (i_rtc_alarm || i_power_switch_state) |-> ##[1:2] s_wake_exit)
        else $error("wake sequence wrong");
    AST_DEFAULTS: assert property (
        o_power_mode == 2'h3 |=> o_main_clk_src == psr_pkg::MAIN_SRC_FAST_RC && !o_xtal_en
        && !o_high_freq_pll_en && o_flash_wait_states == 4'h0 && o_core0_cache_ctrl && o_sub1_reset)
        else $error("wake defaults missing");
    AST_SUPPLY: assert property (
        o_power_mode == 2'h3 && o_wake_cause[psr_pkg::CAUSE_SUPPLY] |-> $past(i_io_supply_ok, 3)
        && !$past(i_io_supply_ok, 2))
        else $error("supply wake without fall");
    AST_RETAIN: assert property (disable iff (i_backup_por)
        !i_backup_cfg_wr && !$past(i_backup_cfg_wr) |=> $stable(o_supply_monitor_mode))
        else $error("retained setting changed");
    AST_GPIO: assert property (o_power_mode inside {2'h1, 2'h2} |=> $stable(o_gpio_dir))
        else $error("gpio moved in low power");
endmodule : psr_top_props
bind psr_top psr_top_props u_props (.i_clock, .i_rst, .i_backup_por, .i_backup_enter, .i_rtc_alarm,
    .i_power_switch_state, .i_io_supply_ok, .i_backup_cfg_wr, .o_regulator_off_out, .o_power_mode,
    .o_wake_cause, .o_supply_monitor_mode, .o_main_clk_src, .o_xtal_en, .o_high_freq_pll_en,
    .o_flash_wait_states, .o_core0_cache_ctrl, .o_sub1_reset, .o_gpio_dir);
`default_nettype wire

// ===== bench/psr_supply_model.sv
// Behavioural main regulator and automatic power switch.
`timescale 1ns/100ps
`default_nettype none
module psr_supply_model (
    // Clock
    input wire logic i_clock,
    // Regulator enable and mains presence
    input wire logic i_regulator_on,
    input wire logic i_mains_back,
    // Switch state toward the device
    output logic o_switch_state
);
    // Reported only while the regulator is shut, so one return of mains gives one wake.
    always_ff @(posedge i_clock)
    begin
        o_switch_state <= i_mains_back && !i_regulator_on;
    end
endmodule : psr_supply_model
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench for the power-state sequencer.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic i_clock, rst, por, bk, wt, ww, bd, tm, rtc, sup, fw, mains, sw, bw, cw, fwr, cwr, rel, reg_on;
    logic xo, lfo, hfo, cache, s1r, s1c, boot, cke, lref, hfl;
    logic [13:0] pins, pen;
    logic [1:0] tmp, mode, msrc, step;
    logic [2:0] bcf;
    wire [2:0] ret;
    logic [3:0] smm, rsm, flash_wait_states;
    logic [5:0] cause;
    logic [8:0] cc;
    logic [31:0] gi, gd, pck;
    logic [11:0] rows [6] = '{12'h041, 12'h082, 12'h108, 12'h210, 12'h420, 12'h820};
    int errors = 0;
    int checks = 0;
    psr_supply_model partner (.i_clock, .i_regulator_on(reg_on), .i_mains_back(mains), .o_switch_state(sw));
    psr_top dut (.i_clock, .i_rst(rst), .i_backup_por(por), .i_backup_enter(bk), .i_wait_enter(wt),
        .i_wait_wake(ww), .i_boot_done(bd), .i_periodic_timer(tm), .i_rtc_alarm(rtc), .i_io_supply_ok(sup),
        .i_wake_pins(pins), .i_wake_pin_en(pen), .i_tamper_inputs(tmp), .i_force_wake_pin(fw),
        .i_power_switch_state(sw), .i_backup_cfg_wr(bw), .i_slow_xtal_select(bcf[2]),
        .i_core_brownout_disable(bcf[1]), .i_backup_por_enable(bcf[0]), .i_supply_monitor_mode(smm),
        .i_clk_cfg_wr(cw), .i_main_clk_src(cc[8:7]), .i_fast_rc_step(cc[6:5]), .i_xtal_en(cc[4]),
        .i_low_freq_pll_en(cc[3]), .i_high_freq_pll_en(cc[2]), .i_lf_pll_ref_xtal(cc[1]),
        .i_hf_pll_from_lf(cc[0]), .i_fws_wr(fwr), .i_flash_wait_states(4'hA), .i_cache_wr(cwr),
        .i_cache_en(1'b0), .i_sub1_release(rel), .i_sub1_stop(1'b0), .i_pclk_wr(cw), .i_pclk_en(32'h0000_00F0),
        .i_gpio_dir(gi), .i_gpio_level(gi), .i_gpio_pull_up(gi), .i_gpio_pull_down(~gi),
        .o_regulator_off_out(reg_on), .o_power_mode(mode), .o_boot_from_rom(boot), .o_wake_cause(cause),
        .o_slow_xtal_select(ret[2]), .o_core_brownout_disable(ret[1]), .o_backup_por_enable(ret[0]),
        .o_supply_monitor_mode(rsm), .o_main_clk_src(msrc), .o_fast_rc_step(step), .o_xtal_en(xo),
        .o_low_freq_pll_en(lfo), .o_high_freq_pll_en(hfo), .o_lf_pll_ref_xtal(lref), .o_hf_pll_from_lf(hfl),
        .o_core_clk_en(cke), .o_periph_clk_en(pck), .o_flash_wait_states(flash_wait_states), .o_core0_cache_ctrl(cache),
        .o_sub1_reset(s1r), .o_sub1_clk_en(s1c), .o_gpio_dir(gd), .o_gpio_level(), .o_gpio_pull_up(),
        .o_gpio_pull_down());
    task automatic end_sim();
        if (errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("FAIL %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic cy(input int n);
        repeat (n) @(negedge i_clock);
    endtask : cy
    task automatic pulse(ref logic s);
        s = 1'b1;
        cy(1);
        s = 1'b0;
    endtask : pulse
    // A mode that never arrives ends the run rather than hanging it.
    task automatic wmode(input logic [1:0] m);
        for (int n = 0; n < 50 && mode !== m; n++)
            cy(1);
        chk(mode, m);
        if (mode !== m)
            end_sim();
    endtask : wmode
    task automatic cfgw();
        {cw, fwr, cwr, rel} = 4'hF;
        cy(1);
        {cw, fwr, cwr, rel} = 4'h0;
        cy(1);
        chk({msrc, flash_wait_states, cache, s1r}, 32'hE8);
        chk(pck, 32'h0000_00F0);
    endtask : cfgw
    initial
    begin
        i_clock = 1'b0;
        forever #2.5 i_clock = ~i_clock;
    end
    initial
    begin
        {rst, por, sup} = 3'b111;
        {bk, wt, ww, bd, tm, rtc, fw, mains, bw, cw, fwr, cwr, rel} = '0;
        {pins, tmp, bcf, smm, gi} = '0;
        pen = 14'h2000;
        cc = 9'h1FF;
        cy(3);
        {rst, por} = 2'b00;
        foreach (rows[k])
        begin
            cfgw();
            pulse(bk);
            chk({mode, reg_on}, 32'h4);
            {mains, fw, tmp[1], pins[13], rtc, tm} = rows[k][11:6];
            wmode(2'h3);
            chk({cause, reg_on}, {rows[k][5:0], 1'b1});
            {mains, fw, tmp[1], pins[13], rtc, tm} = '0;
            wmode(2'h0);
            chk({msrc, step, xo, lfo, hfo, flash_wait_states, cache, s1r, s1c}, 32'h6);
            chk(pck, 32'h0);
        end
        bcf = 3'b110;
        smm = 4'h3;
        pulse(bw);
        cy(1);
        chk({ret, rsm}, 32'h63);
        cfgw();
        chk({lref, hfl}, 32'h3);
        rst = 1'b1;
        cy(2);
        rst = 1'b0;
        cy(1);
        chk({ret, rsm}, 32'h63);
        chk({msrc, step, xo, lfo, hfo, flash_wait_states, cache, s1r, s1c}, 32'h6);
        sup = 1'b0;
        cy(2);
        pulse(bk);
        cy(2);
        sup = 1'b1;
        cy(3);
        chk(mode, 32'h2);
        sup = 1'b0;
        wmode(2'h3);
        chk(cause, 32'h4);
        wmode(2'h0);
        sup = 1'b1;
        gi = 32'hA5A5_0F0F;
        cy(2);
        pulse(wt);
        gi = ~gi;
        cy(3);
        chk(gd, 32'hA5A5_0F0F);
        chk(cke, 32'h0);
        pulse(ww);
        chk({mode, cke}, 32'h1);
        {por, rst} = 2'b11;
        cy(2);
        {por, rst} = 2'b00;
        cy(1);
        chk({boot, ret, rsm}, 32'h90);
        pulse(bd);
        cy(1);
        chk(boot, 32'h0);
        end_sim();
    end
endmodule : testbench
`default_nettype wire
